//--- hw/byte_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; one clock, active-low async reset.
 */
`timescale 1ns/1ps
module byte_fifo #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store_q [DEPTH];
    logic [WIDTH-1:0] store_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = store_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb
    begin
        store_d = store_q;
        wr_d = wr_q;
        rd_d = rd_q;
        count_d = count_q;
        if (push)
        begin
            store_d[wr_q] = in_data;
            wr_d = wr_q + AW'(1);
        end
        if (pop)
            rd_d = rd_q + AW'(1);
        if (push && !pop)
            count_d = count_q + (AW+1)'(1);
        else if (pop && !push)
            count_d = count_q - (AW+1)'(1);
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            store_q <= '{default: '0};
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else
        begin
            store_q <= store_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            count_q <= count_d;
        end
    end

    property p_fifo_fill;
        @(posedge clock) disable iff (!rst_n)
        (push && !pop) |=> (count_q == $past(count_q) + (AW+1)'(1));
    endproperty
    a_fifo_fill: assert property (p_fifo_fill) else $error("fifo count did not rise on push");
endmodule

//--- hw/eeprom_pkg.sv
/*
 * Shared constants and types of the two-wire serial memory slave.
 * Assumes a 50 MHz system clock; all bus timing is derived from sampled pins.
 */
package eeprom_pkg;
    localparam logic [3:0] DEV_TYPE_ID = 4'ha;
    localparam logic [2:0] DEV_SELECT = 3'h0;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned PAGE_BITS = 4;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned MEM_BYTES = 256;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FIFO_WIDTH = PAGE_BITS + BYTE_BITS;
    localparam int unsigned CLK_FREQ_HZ = 50000000;
    localparam int unsigned WRITE_TIME_US = 5000;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * (CLK_FREQ_HZ / 1000000);
    localparam int unsigned TIMER_BITS = 18;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] TX_LAST = 4'h7;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_RX_ACK, PH_TX, PH_TX_ACK, PH_IGNORE} phase_t;
    typedef enum logic [1:0] {BYTE_SLAVE, BYTE_WORD, BYTE_DATA} role_t;
endpackage

//--- hw/eeprom_slave.sv
/*
 * Two-wire slave command engine of a 256-byte serial memory with 16-byte pages.
 * Assumes scl and sda come from pins (synchronised here) and that the bus clock
 * is at least eight system clocks per period. reset_active is on this clock.
 */
`timescale 1ns/1ps
module eeprom_slave #(
    parameter int unsigned WRITE_CYCLES_P = eeprom_pkg::WRITE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic reset_active,
    output logic write_busy
);
    import eeprom_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release and pin sampling
    logic [1:0] rst_q;
    logic rst_sync_n;
    logic [1:0] pins_s;
    logic scl_s, sda_s, scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_sync_n = rst_q[1];

    pin_sync #(.WIDTH(2)) u_sync (
        .clock(clock),
        .rst_n(rst_sync_n),
        .d({scl_i, sda_i}),
        .q(pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // storage, page buffer and write fifo
    logic [7:0] mem_q [MEM_BYTES];
    logic [7:0] mem_d [MEM_BYTES];
    logic [7:0] pbuf_q [PAGE_BYTES];
    logic [7:0] pbuf_d [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pval_q, pval_d;
    logic push_valid, push_ready, pop_valid, pop_ready;
    logic [FIFO_WIDTH-1:0] pop_data;

    ////////////////////////////////////////////////////////////////////////////////
    // protocol state
    phase_t phase_q, phase_d;
    role_t role_q, role_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d, addr_q, addr_d;
    logic sda_oe_q, oe_d, acked_q, acked_d, rw_q, rw_d, pending_q, pending_d;
    logic commit_q, commit_d, busy_q, busy_d, prog_done;
    logic [3:0] page_hi_q, page_hi_d;
    logic [TIMER_BITS-1:0] timer_q, timer_d;
    logic byte_done, addr_match, addr_ack, tx_load;

    assign byte_done = (phase_q == PH_RX) && scl_fall && (cnt_q == BIT_LAST);
    assign addr_match = (shift_q[7:1] == {DEV_TYPE_ID, DEV_SELECT});
    assign addr_ack = addr_match && !busy_q && !commit_q && !reset_active;
    assign push_valid = byte_done && (role_q == BYTE_DATA) && !reset_active;

    byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_sync_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data({addr_q[3:0], shift_q}),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );
    assign pop_ready = ~busy_q;

    always_comb
    begin
        phase_d = phase_q;
        role_d = role_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        addr_d = addr_q;
        oe_d = sda_oe_q;
        acked_d = acked_q;
        rw_d = rw_q;
        pending_d = pending_q;
        tx_load = 1'b0;
        if (reset_active)
        begin
            phase_d = PH_IDLE;
            oe_d = 1'b0;
            pending_d = 1'b0;
        end
        else if (start_det)
        begin
            phase_d = PH_RX;
            role_d = BYTE_SLAVE;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end
        else if (stop_det)
        begin
            phase_d = PH_IDLE;
            oe_d = 1'b0;
            pending_d = 1'b0;
        end
        else
        begin
            unique case (phase_q)
                PH_IDLE, PH_IGNORE:
                begin
                end
                PH_RX:
                begin
                    if (scl_rise && cnt_q != BIT_LAST)
                    begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        phase_d = PH_RX_ACK;
                        unique case (role_q)
                            BYTE_SLAVE:
                            begin
                                oe_d = addr_ack;
                                rw_d = shift_q[0];
                                if (!addr_ack)
                                    phase_d = PH_IGNORE;
                            end
                            BYTE_WORD:
                            begin
                                oe_d = 1'b1;
                                addr_d = shift_q;
                            end
                            default:
                            begin
                                oe_d = push_ready;
                                if (push_ready)
                                begin
                                    addr_d = {addr_q[7:4], addr_q[3:0] + 4'h1};
                                    pending_d = 1'b1;
                                end
                                else
                                    phase_d = PH_IGNORE;
                            end
                        endcase
                    end
                end
                PH_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        phase_d = PH_RX;
                        role_d = (role_q == BYTE_SLAVE) ? BYTE_WORD : BYTE_DATA;
                        tx_load = (role_q == BYTE_SLAVE) && rw_q;
                    end
                end
                PH_TX:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == TX_LAST)
                        begin
                            phase_d = PH_TX_ACK;
                            oe_d = 1'b0;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_d = ~shift_q[6];
                        end
                    end
                end
                PH_TX_ACK:
                begin
                    if (scl_rise)
                        acked_d = ~sda_s;
                    else if (scl_fall)
                    begin
                        tx_load = acked_q;
                        if (!acked_q)
                            phase_d = PH_IGNORE;
                    end
                end
                default:
                    phase_d = PH_IDLE;
            endcase
            if (tx_load)
            begin
                shift_d = mem_q[addr_q];
                addr_d = addr_q + 8'h01;
                oe_d = ~mem_q[addr_q][7];
                cnt_d = 4'h0;
                phase_d = PH_TX;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            phase_q <= PH_IDLE;
            role_q <= BYTE_SLAVE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            addr_q <= ADDR_RESET;
            sda_oe_q <= 1'b0;
            acked_q <= 1'b0;
            rw_q <= 1'b0;
            pending_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            role_q <= role_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            sda_oe_q <= oe_d;
            acked_q <= acked_d;
            rw_q <= rw_d;
            pending_q <= pending_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // internal write cycle
    always_comb
    begin
        commit_d = commit_q;
        page_hi_d = page_hi_q;
        busy_d = busy_q;
        timer_d = timer_q;
        prog_done = 1'b0;
        if (stop_det && pending_q && !reset_active)
        begin
            commit_d = 1'b1;
            page_hi_d = addr_q[7:4];
        end
        else if (reset_active && !busy_q)
            commit_d = 1'b0;
        else if (commit_q && !pop_valid && !busy_q)
        begin
            commit_d = 1'b0;
            busy_d = 1'b1;
            timer_d = '0;
        end
        else if (busy_q)
        begin
            if (timer_q == TIMER_BITS'(WRITE_CYCLES_P - 1))
            begin
                busy_d = 1'b0;
                prog_done = 1'b1;
            end
            else
                timer_d = timer_q + TIMER_BITS'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            commit_q <= 1'b0;
            page_hi_q <= 4'h0;
            busy_q <= 1'b0;
            timer_q <= '0;
        end
        else
        begin
            commit_q <= commit_d;
            page_hi_q <= page_hi_d;
            busy_q <= busy_d;
            timer_q <= timer_d;
        end
    end

    genvar g;
    for (g = 0; g < PAGE_BYTES; g++)
    begin : g_page
        always_comb
        begin
            pbuf_d[g] = pbuf_q[g];
            pval_d[g] = pval_q[g];
            if (prog_done || (reset_active && !busy_q))
                pval_d[g] = 1'b0;
            else if (pop_valid && pop_ready && pop_data[11:8] == PAGE_BITS'(g))
            begin
                pbuf_d[g] = pop_data[7:0];
                pval_d[g] = 1'b1;
            end
        end
        always_ff @(posedge clock or negedge rst_sync_n)
        begin
            if (!rst_sync_n)
            begin
                pbuf_q[g] <= ERASED_BYTE;
                pval_q[g] <= 1'b0;
            end
            else
            begin
                pbuf_q[g] <= pbuf_d[g];
                pval_q[g] <= pval_d[g];
            end
        end
    end

    always_comb
    begin
        mem_d = mem_q;
        if (prog_done)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                if (pval_q[i])
                    mem_d[{page_hi_q, PAGE_BITS'(i)}] = pbuf_q[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            mem_q <= '{default: ERASED_BYTE};
        else
            mem_q <= mem_d;
    end

    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;
    assign write_busy = busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_addr_ack;
        @(posedge clock) disable iff (!rst_sync_n)
        (byte_done && role_q == BYTE_SLAVE && addr_ack) |=> (sda_oe_q && phase_q == PH_RX_ACK);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

    property p_busy_nack;
        @(posedge clock) disable iff (!rst_sync_n)
        (byte_done && role_q == BYTE_SLAVE && !reset_active && (busy_q || commit_q))
            |=> (!sda_oe_q && phase_q == PH_IGNORE);
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("poll acked while busy");

    property p_word_ack;
        @(posedge clock) disable iff (!rst_sync_n)
        (byte_done && role_q == BYTE_WORD && !reset_active) |=> (sda_oe_q && addr_q == $past(shift_q));
    endproperty
    a_word_ack: assert property (p_word_ack) else $error("word address not taken");

    property p_page_inc;
        @(posedge clock) disable iff (!rst_sync_n)
        (byte_done && role_q == BYTE_DATA && push_ready && !reset_active)
            |=> (sda_oe_q && addr_q[7:4] == $past(addr_q[7:4])
                && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1);
    endproperty
    a_page_inc: assert property (p_page_inc) else $error("page address step wrong");

    property p_read_inc;
        @(posedge clock) disable iff (!rst_sync_n)
        tx_load |=> (addr_q == $past(addr_q) + 8'h01 && phase_q == PH_TX && cnt_q == 4'h0);
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("read address step wrong");

    property p_tx_release;
        @(posedge clock) disable iff (!rst_sync_n)
        (phase_q == PH_TX_ACK) |-> !sda_oe_q;
    endproperty
    a_tx_release: assert property (p_tx_release) else $error("sda held in master ack");

    property p_reset_abort;
        @(posedge clock) disable iff (!rst_sync_n)
        reset_active |=> (phase_q == PH_IDLE && !sda_oe_q);
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("transfer survived reset");

    property p_commit;
        @(posedge clock) disable iff (!rst_sync_n)
        (stop_det && pending_q && !reset_active) |=> commit_q ##[1:17] busy_q;
    endproperty
    a_commit: assert property (p_commit) else $error("stop did not start write");

    property p_mismatch;
        @(posedge clock) disable iff (!rst_sync_n)
        (byte_done && role_q == BYTE_SLAVE && !addr_match && !reset_active)
            |=> (phase_q == PH_IGNORE && !sda_oe_q);
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("foreign address answered");
endmodule

//--- hw/pin_sync.sv
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes inputs are asynchronous to clock; q is safe for any logic.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    genvar g;
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
        logic meta_q;
        logic sync_q;
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
            begin
                meta_q <= 1'b1;
                sync_q <= 1'b1;
            end
            else
            begin
                meta_q <= d[g];
                sync_q <= meta_q;
            end
        end
        assign q[g] = sync_q;
    end
endmodule

//--- test/bus_master_model.sv
/*
 * Two-wire bus master model: drives scl, pulls sda low when sda_pull is set.
 * Assumes a 50 MHz clock; a quarter bit is two clocks, so one bit is 160 ns.
 */
`timescale 1ns/1ps
module bus_master_model (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl_line,
    output logic sda_pull
);
    initial
    begin
        scl_line = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic qtr;
        repeat (2) @(negedge clock);
    endtask
    // release sda with scl low first, so a repeated start works too
    task automatic start;
        sda_pull = 1'b0;
        qtr();
        scl_line = 1'b1;
        qtr();
        sda_pull = 1'b1;
        qtr();
        scl_line = 1'b0;
        qtr();
    endtask
    task automatic stop;
        sda_pull = 1'b1;
        qtr();
        scl_line = 1'b1;
        qtr();
        sda_pull = 1'b0;
        qtr();
    endtask
    task automatic clk_bit(input logic b, output logic s);
        sda_pull = ~b;
        qtr();
        scl_line = 1'b1;
        qtr();
        s = sda_line;
        qtr();
        scl_line = 1'b0;
        qtr();
    endtask
    // msb first, ninth clock released; ack is 1 when the slave pulled low
    task automatic put(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(v[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic get(input logic ack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, s);
            v[i] = s;
        end
        clk_bit(~ack, s);
    endtask
endmodule

//--- test/tb_top.sv
/*
 * Self-checking bench of the serial memory slave, driven through a master model.
 * Assumes the open-drain bus has pull-ups; shortened internal write time.
 */
`timescale 1ns/1ps
module tb_top;
    import eeprom_pkg::*;
    localparam int unsigned WCYC = 200;
    typedef struct packed {logic [7:0] addr; logic [7:0] data;} row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic reset_active = 1'b0;
    logic sda_o, sda_oe, write_busy, scl_line, sda_pull, sda_line, ack;
    logic [7:0] rd;
    int bad_count = 0;
    int checked = 0;
    row_t rows [4] = '{'{8'h00, 8'h5a}, '{8'h01, 8'hc3}, '{8'h80, 8'h3c}, '{8'hff, 8'h00}};
    assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
    eeprom_slave #(.WRITE_CYCLES_P(WCYC)) eeprom_slave_i (.clock(clock), .rst_n(rst_n),
        .scl_i(scl_line), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .reset_active(reset_active), .write_busy(write_busy));
    bus_master_model bus_master_model_i (.clock(clock), .sda_line(sda_line),
        .scl_line(scl_line), .sda_pull(sda_pull));
    always #10 clock = ~clock;
    task automatic give_verdict;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic addr_ph(input logic [7:0] a, input logic [7:0] w);
        bus_master_model_i.start();
        bus_master_model_i.put(a, ack);
        chk1("address ack", 1'b1, ack);
        bus_master_model_i.put(w, ack);
        chk1("word ack", 1'b1, ack);
    endtask
    task automatic wait_idle;
        ack = 1'b0;
        for (int n = 0; n < 20 && !ack; n++)
        begin
            bus_master_model_i.start();
            bus_master_model_i.put(8'ha0, ack);
            bus_master_model_i.stop();
        end
        chk1("poll ack", 1'b1, ack);
    endtask
    task automatic seq_rd(input int n, input logic [7:0] first);
        bus_master_model_i.start();
        bus_master_model_i.put(8'ha1, ack);
        chk1("read address ack", 1'b1, ack);
        for (int i = 0; i < n; i++)
        begin
            bus_master_model_i.get(i < n - 1, rd);
            chk8("read byte", first + 8'(i), rd);
        end
        bus_master_model_i.stop();
    endtask
    initial
    begin
        repeat (60000) @(posedge clock);
        bad_count++;
        give_verdict();
    end
    initial
    begin
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        chk1("busy after reset", 1'b0, write_busy);
        chk1("oe after reset", 1'b0, sda_oe);
        chk1("sda drive level", 1'b0, sda_o);
        foreach (rows[k])
        begin
            addr_ph(8'ha0, rows[k].addr);
            bus_master_model_i.put(rows[k].data, ack);
            chk1("data ack", 1'b1, ack);
            bus_master_model_i.stop();
            repeat (6) @(negedge clock);
            chk1("busy after stop", 1'b1, write_busy);
            bus_master_model_i.start();
            bus_master_model_i.put(8'ha0, ack);
            bus_master_model_i.stop();
            chk1("poll while busy", 1'b0, ack);
            wait_idle();
            addr_ph(8'ha0, rows[k].addr);
            seq_rd(1, rows[k].data);
        end
        $display("test byte rows done");
        addr_ph(8'ha0, 8'h4e);
        for (int i = 0; i < 18; i++)
        begin
            bus_master_model_i.put(8'h10 + 8'(i), ack);
            chk1("page data ack", 1'b1, ack);
        end
        bus_master_model_i.stop();
        wait_idle();
        for (int o = 0; o < 16; o++)
        begin
            addr_ph(8'ha0, 8'h40 + 8'(o));
            seq_rd(1, 8'h12 + 8'(o));
        end
        $display("test page wrap done");
        addr_ph(8'ha0, 8'hfe);
        bus_master_model_i.start();
        bus_master_model_i.put(8'ha1, ack);
        chk1("wrap read ack", 1'b1, ack);
        bus_master_model_i.get(1'b1, rd);
        chk8("byte fe", 8'hff, rd);
        bus_master_model_i.get(1'b1, rd);
        chk8("byte ff", 8'h00, rd);
        bus_master_model_i.get(1'b0, rd);
        chk8("wrapped byte 00", 8'h5a, rd);
        bus_master_model_i.stop();
        seq_rd(1, 8'hc3);
        $display("test sequential wrap done");
        bus_master_model_i.start();
        bus_master_model_i.put(8'hb0, ack);
        chk1("foreign address", 1'b0, ack);
        bus_master_model_i.put(8'h00, ack);
        chk1("ignored byte", 1'b0, ack);
        bus_master_model_i.start();
        bus_master_model_i.put(8'ha2, ack);
        chk1("select mismatch", 1'b0, ack);
        bus_master_model_i.stop();
        $display("test foreign address done");
        addr_ph(8'ha0, 8'h10);
        reset_active = 1'b1;
        bus_master_model_i.put(8'h99, ack);
        chk1("data under reset", 1'b0, ack);
        bus_master_model_i.stop();
        reset_active = 1'b0;
        addr_ph(8'ha0, 8'h11);
        bus_master_model_i.put(8'h77, ack);
        bus_master_model_i.stop();
        repeat (6) @(negedge clock);
        reset_active = 1'b1;
        repeat (WCYC + 20) @(negedge clock);
        chk1("write done under reset", 1'b0, write_busy);
        reset_active = 1'b0;
        addr_ph(8'ha0, 8'h10);
        seq_rd(1, 8'hff);
        seq_rd(1, 8'h77);
        $display("test device reset done");
        give_verdict();
    end
endmodule
